// file: logic/ir_carrier_pkg.sv
// package: register map, field layout and types of the carrier generator
package ir_carrier_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] idx_period_reload = 8'hcd;
  localparam logic [7:0] idx_output_control = 8'hda;
  localparam logic [7:0] idx_counter_value = 8'hdb;
  localparam logic [7:0] idx_duty_compare = 8'he8;
  localparam logic [11:0] addr_period_reload = 12'h334;
  localparam logic [11:0] addr_output_control = 12'h368;
  localparam logic [11:0] addr_counter_value = 12'h36c;
  localparam logic [11:0] addr_duty_compare = 12'h3a0;
  localparam int addr_w = 12;
  localparam int pos_pin_function_enable = 1;
  localparam int pos_carrier_drive_enable = 0;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] count_max = 8'hff;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  localparam int clk_mhz = 200;
  localparam int count_rate_mhz = 4;
  localparam int sync_stages = 2;

  typedef struct packed {
    logic pin_function_enable;
    logic carrier_drive_enable;
  } output_control_t;

  typedef struct packed {
    logic level;
    logic oe_n;
    logic gpio_select;
  } pin_drive_t;
endpackage : ir_carrier_pkg

// file: logic/ir_carrier_generator.sv
// infrared carrier generator with axi4-lite register slave
// Summary of operation
// - carrier reaches pin only when pin and carrier enables are both one.
// - pin enable zero leaves the pin as a general-purpose port pin.
// - pin enable one, carrier enable zero holds the pin low.
// - power-down forces the pin low whatever the enables say.
// - counter is eight bits and counts up by one per count tick.
// - count tick comes only from the high-speed oscillator, no prescaler.
// - the timer raises no interrupt; it only makes the waveform.
// - on enable the output starts high; the counter is not reloaded and counts on from its current value.
// - counter equal to duty compare turns the output low.
// - wrap from 0xff ends low phase, reloads counter, next period high.
// - reload writes go to a holding buffer, active at next overflow.
// - high lasts duty minus reload counts, low lasts 256 minus duty.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_generator #(
  parameter int count_width = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_clk,
  input wire logic power_down,
  input wire logic gpio_level,
  input wire logic gpio_oe_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic infrared_output_pin,
  output logic infrared_output_pin_oe_n,
  output logic carrier_phase_high
);
  // oscillator sampled through two flops, rising edge gives the count tick
  logic [2:0] osc_sync;
  wire osc_tick = osc_sync[1] & ~osc_sync[2];
  logic pd_s1, pd_s2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync <= 3'h0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], osc_clk};
      pd_s1 <= power_down;
      pd_s2 <= pd_s1;
    end
  end

  // write channel capture, either order
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  wire aw_now = aw_held | s_axi_awvalid;
  wire w_now = w_held | s_axi_wvalid;
  wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_reload = wr_lane0 && wr_addr == ir_carrier_pkg::addr_period_reload;
  wire wr_ctrl = wr_lane0 && wr_addr == ir_carrier_pkg::addr_output_control;
  wire wr_count = wr_lane0 && wr_addr == ir_carrier_pkg::addr_counter_value;
  wire wr_duty = wr_lane0 && wr_addr == ir_carrier_pkg::addr_duty_compare;
  wire wr_hit = wr_addr == ir_carrier_pkg::addr_period_reload
    || wr_addr == ir_carrier_pkg::addr_output_control
    || wr_addr == ir_carrier_pkg::addr_counter_value
    || wr_addr == ir_carrier_pkg::addr_duty_compare;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ir_carrier_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ir_carrier_pkg::resp_okay
                              : ir_carrier_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // registers and carrier timer
  ir_carrier_pkg::output_control_t ctrl;
  logic [count_width-1:0] reload_buffer, reload_active, duty, count;
  logic carrier_high;
  wire drive_on = ctrl.pin_function_enable & ctrl.carrier_drive_enable;
  wire [count_width-1:0] count_step = count_width'(count + 1'b1);
  wire overflow = osc_tick && count == ir_carrier_pkg::count_max;
  // low as the count steps onto the duty value
  wire duty_hit = osc_tick && !overflow && count_step == duty;
  logic drive_on_q;
  wire enable_rise = drive_on & ~drive_on_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      reload_buffer <= ir_carrier_pkg::reset_byte;
      reload_active <= ir_carrier_pkg::reset_byte;
      duty <= ir_carrier_pkg::reset_byte;
      count <= ir_carrier_pkg::reset_byte;
      carrier_high <= 1'b0;
      drive_on_q <= 1'b0;
    end else begin
      drive_on_q <= drive_on;
      if (wr_ctrl) begin
        ctrl.pin_function_enable <=
          wr_data[ir_carrier_pkg::pos_pin_function_enable];
        ctrl.carrier_drive_enable <=
          wr_data[ir_carrier_pkg::pos_carrier_drive_enable];
      end
      if (wr_duty) begin
        duty <= wr_data[7:0];
      end
      if (wr_reload) begin
        reload_buffer <= wr_data[7:0];
      end else if (overflow) begin
        reload_active <= reload_buffer;
      end
      if (wr_reload && overflow) begin
        reload_active <= wr_data[7:0];
      end
      if (wr_count) begin
        count <= wr_data[7:0];
      end else if (overflow) begin
        count <= wr_reload ? wr_data[7:0] : reload_buffer;
      end else if (osc_tick) begin
        count <= count_step;
      end
      if (enable_rise || overflow) begin
        carrier_high <= 1'b1;
      end else if (duty_hit) begin
        carrier_high <= 1'b0;
      end
    end
  end

  // pin steering; no interrupt output exists
  ir_carrier_pkg::pin_drive_t pin;
  always_comb begin
    pin.gpio_select = ~ctrl.pin_function_enable;
    if (pd_s2) begin
      pin.level = 1'b0;
      pin.oe_n = 1'b0;
    end else if (pin.gpio_select) begin
      pin.level = gpio_level;
      pin.oe_n = gpio_oe_n;
    end else begin
      pin.level = drive_on & carrier_high;
      pin.oe_n = 1'b0;
    end
  end
  assign infrared_output_pin = pin.level;
  assign infrared_output_pin_oe_n = pin.oe_n;
  assign carrier_phase_high = carrier_high;

  // read channel
  wire [7:0] rd_sel =
    s_axi_araddr == ir_carrier_pkg::addr_output_control
      ? {6'h00, ctrl.pin_function_enable, ctrl.carrier_drive_enable}
    : s_axi_araddr == ir_carrier_pkg::addr_counter_value ? count
    : 8'h00;
  wire rd_hit = s_axi_araddr == ir_carrier_pkg::addr_output_control
    || s_axi_araddr == ir_carrier_pkg::addr_counter_value
    || s_axi_araddr == ir_carrier_pkg::addr_period_reload
    || s_axi_araddr == ir_carrier_pkg::addr_duty_compare;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ir_carrier_pkg::resp_okay;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_sel};
      s_axi_rresp <= rd_hit ? ir_carrier_pkg::resp_okay
                            : ir_carrier_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  property p_pd_low;
    @(posedge clk) disable iff (!rst_n)
      pd_s2 |-> !infrared_output_pin && !infrared_output_pin_oe_n;
  endproperty
  a_pd_low: assert property (p_pd_low)
    else $error("pin not low in power-down");
  property p_carrier_off_low;
    @(posedge clk) disable iff (!rst_n)
      (!pd_s2 && ctrl.pin_function_enable && !ctrl.carrier_drive_enable)
        |-> !infrared_output_pin && !infrared_output_pin_oe_n;
  endproperty
  a_carrier_off_low: assert property (p_carrier_off_low)
    else $error("pin not held low");
  property p_gpio_pass;
    @(posedge clk) disable iff (!rst_n)
      (!pd_s2 && !ctrl.pin_function_enable)
        |-> infrared_output_pin == gpio_level
            && infrared_output_pin_oe_n == gpio_oe_n;
  endproperty
  a_gpio_pass: assert property (p_gpio_pass)
    else $error("gpio not passed");
  property p_drive_only_enabled;
    @(posedge clk) disable iff (!rst_n)
      (!pd_s2 && ctrl.pin_function_enable && infrared_output_pin)
        |-> drive_on && carrier_high;
  endproperty
  a_drive_only_enabled: assert property (p_drive_only_enabled)
    else $error("carrier without enables");
  property p_wrap_reload;
    @(posedge clk) disable iff (!rst_n)
      (overflow && !wr_count && !wr_reload) |=> count == $past(reload_buffer);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload)
    else $error("no reload at wrap");
  property p_wrap_high;
    @(posedge clk) disable iff (!rst_n) overflow |=> carrier_high;
  endproperty
  a_wrap_high: assert property (p_wrap_high)
    else $error("period not starting high");
  property p_enable_high;
    @(posedge clk) disable iff (!rst_n) enable_rise |=> carrier_high;
  endproperty
  a_enable_high: assert property (p_enable_high)
    else $error("carrier not starting high");
  property p_duty_low;
    @(posedge clk) disable iff (!rst_n)
      (duty_hit && !overflow && !enable_rise) |=> !carrier_high;
  endproperty
  a_duty_low: assert property (p_duty_low)
    else $error("no low at duty match");
  property p_count_step;
    @(posedge clk) disable iff (!rst_n)
      (osc_tick && !overflow && !wr_count) |=> count == $past(count) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step");
  property p_count_hold;
    @(posedge clk) disable iff (!rst_n)
      (!osc_tick && !wr_count) |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("count moved without tick");
  property p_reload_held;
    @(posedge clk) disable iff (!rst_n) !overflow |=> $stable(reload_active);
  endproperty
  a_reload_held: assert property (p_reload_held)
    else $error("reload changed early");
  property p_write_write;
    @(posedge clk) disable iff (!rst_n)
      wr_count |=> count == $past(wr_data[7:0]);
  endproperty
  a_write_write: assert property (p_write_write)
    else $error("counter write lost");
  c_overflow: cover property (@(posedge clk) disable iff (!rst_n)
    overflow && drive_on);
  c_duty: cover property (@(posedge clk) disable iff (!rst_n)
    duty_hit && drive_on);
  c_pd: cover property (@(posedge clk) disable iff (!rst_n)
    pd_s2 && drive_on);
endmodule // ir_carrier_generator
`default_nettype wire

// file: verification/ir_emitter_model.sv
// emitter model: measures carrier run lengths seen on the pin
`timescale 1ns/1ps
`default_nettype none
module ir_emitter_model (
  input wire logic clk,
  input wire logic level,
  input wire logic oe_n,
  output int high_len,
  output int low_len,
  output int periods
);
  int run;
  logic last;
  initial begin
    run = 0;
    last = 1'b0;
    high_len = 0;
    low_len = 0;
    periods = 0;
  end
  // lengths in clk cycles, only while the pin is driven
  always @(posedge clk) begin
    if (oe_n !== 1'b0) begin
      run <= 0;
    end else if (level === last) begin
      run <= run + 1;
    end else begin
      if (last) high_len <= run + 1;
      else low_len <= run + 1;
      if (level) periods <= periods + 1;
      run <= 0;
    end
    last <= level;
  end
endmodule // ir_emitter_model
`default_nettype wire

// file: verification/ir_carrier_generator_tb.sv
// self-checking bench of the carrier generator
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_generator_tb;
  localparam logic [11:0] a_rl = ir_carrier_pkg::addr_period_reload;
  localparam logic [11:0] a_ct = ir_carrier_pkg::addr_output_control;
  localparam logic [11:0] a_cv = ir_carrier_pkg::addr_counter_value;
  localparam logic [11:0] a_du = ir_carrier_pkg::addr_duty_compare;
  localparam logic [1:0] ok = ir_carrier_pkg::resp_okay;
  localparam logic [1:0] er = ir_carrier_pkg::resp_slverr;
  localparam int dv = 8;
  logic clk = 0, rst_n = 0, osc_clk = 0, osc_run = 0, power_down = 0;
  logic gpio_level = 0, gpio_oe_n = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic pin, pin_oe_n, bad, phase;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  int mismatches = 0, compares = 0, ticks = 0, high_len, low_len, periods;
  initial begin
    forever #2.5 clk = ~clk;
  end
  always #20 osc_clk = osc_run & ~osc_clk;
  always @(posedge osc_clk) ticks++;
  ir_carrier_generator i_dut (.clk(clk), .rst_n(rst_n), .osc_clk(osc_clk),
    .power_down(power_down), .gpio_level(gpio_level), .gpio_oe_n(gpio_oe_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .infrared_output_pin(pin),
    .infrared_output_pin_oe_n(pin_oe_n), .carrier_phase_high(phase));
  ir_emitter_model i_emitter (.clk(clk), .level(pin), .oe_n(pin_oe_n),
    .high_len(high_len), .low_len(low_len), .periods(periods));
  task automatic finish_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timed_out();
    mismatches++;
    finish_test();
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic [1:0] r);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) timed_out();
    check(bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d,
    input logic [1:0] r);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) timed_out();
    check(rresp, r);
    check(rdata, {24'h0, d});
  endtask
  task automatic wait_periods(input int k);
    int p = periods;
    int n = 0;
    while (periods < p + k && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) timed_out();
  endtask
  task automatic t_reset();
    rd(a_cv, 8'h00, ok);
    rd(a_ct, 8'h00, ok);
    rd(a_rl, 8'h00, ok);
    rd(a_du, 8'h00, ok);
    rd(12'h000, 8'h00, er);
    wr(12'h004, 8'h5a, er);
  endtask
  task automatic t_pins();
    wr(a_ct, 8'h01, ok);
    for (int i = 0; i < 2; i++) begin
      gpio_level <= i[0];
      gpio_oe_n <= ~i[0];
      repeat (3) @(posedge clk);
      check(pin, i[0]);
      check(pin_oe_n, !i[0]);
    end
    wr(a_ct, 8'h02, ok);
    repeat (3) @(posedge clk);
    check({pin, pin_oe_n}, 2'b00);
    check(phase, 1'b0);
  endtask
  task automatic t_count();
    int t0 = ticks;
    int n = 0;
    wr(a_cv, 8'h5a, ok);
    rd(a_cv, 8'h5a, ok);
    osc_run <= 1'b1;
    while (ticks < t0 + 5 && n < 500) begin
      @(posedge clk);
      n++;
    end
    osc_run <= 1'b0;
    if (n >= 500) timed_out();
    repeat (10) @(posedge clk);
    rd(a_cv, 8'h5f, ok);
  endtask
  task automatic t_carrier();
    wr(a_cv, 8'hf0, ok);
    wr(a_rl, 8'hf0, ok);
    wr(a_du, 8'hf4, ok);
    wr(a_ct, 8'h03, ok);
    repeat (2) @(posedge clk);
    check({pin, pin_oe_n}, 2'b10);
    check(phase, 1'b1);
    rd(a_cv, 8'hf0, ok);
    osc_run <= 1'b1;
    wait_periods(2);
    check(high_len, 4 * dv);
    check(low_len, 12 * dv);
    wr(a_rl, 8'he8, ok);
    wait_periods(2);
    check(high_len, 12 * dv);
    check(low_len, 12 * dv);
  endtask
  task automatic t_power();
    bad = 1'b0;
    power_down <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (200) begin
      @(posedge clk);
      if (pin !== 1'b0 || pin_oe_n !== 1'b0) bad = 1'b1;
    end
    check(bad, 1'b0);
    power_down <= 1'b0;
    osc_run <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pins();
    t_count();
    t_carrier();
    t_power();
    finish_test();
  end
endmodule // ir_carrier_generator_tb
`default_nettype wire
